//--- logic/twelve_bit_interval_timer.sv
/*
 holds the interval timer: axi4-lite registers, count clock selection, counter and interrupt.
 assumes count clocks arrive as slow pins far below the 100 mhz system clock.
*/
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "twelve_bit_interval_timer_regs.svh"

module twelve_bit_interval_timer (
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    input  wire logic                          ce,
    input  wire logic                          subsystem_clock,
    input  wire logic                          low_speed_osc_clock,
    input  wire logic                          standby,
    input  wire logic                          cpu_on_sub_clock,
    output var  logic                          sub_clock_peripheral_en,
    output var  logic                          interval_irq,
    output var  logic                          wake_request,
    output var  logic                          irq,
    input  wire interval_timer_pkg::addr_type  s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output var  logic                          s_axi_awready,
    input  wire interval_timer_pkg::word_type  s_axi_wdata,
    input  wire interval_timer_pkg::strb_type  s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output var  logic                          s_axi_wready,
    output var  interval_timer_pkg::resp_type  s_axi_bresp,
    output var  logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire interval_timer_pkg::addr_type  s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output var  logic                          s_axi_arready,
    output var  interval_timer_pkg::word_type  s_axi_rdata,
    output var  interval_timer_pkg::resp_type  s_axi_rresp,
    output var  logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready
);
    import interval_timer_pkg::*;

    addr_type   aw_addr_q;
    logic       aw_full_q;
    word_type   w_data_q;
    strb_type   w_strb_q;
    logic       w_full_q;
    logic       do_write;
    logic [19:0] wr_idx;
    logic [19:0] rd_idx;
    logic       wr_ctrl;
    logic       wr_speed;
    logic       wr_peren;
    logic       wr_stat;
    logic       wr_mask;
    logic       wr_hit;
    logic       rd_hit;
    word_type   rd_word;

    logic       run_req_q;
    logic       run_q;
    count_type  cmp_q;
    count_type  cnt_q;
    logic [7:0] speed_q;
    logic [7:0] peren_q;
    logic       stat_q;
    logic       mask_q;
    logic       irq_pulse_q;

    logic [1:0] src_rise;
    logic       tick;
    logic       match;
    logic       timer_clk_on;

    // ==========================================================
    // count clock pins, one synchroniser per source
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : g_src
            pin_edge_sync u_sync (
                .clk    (clk),
                .rst_n  (rst_n),
                .ce     (ce),
                .pin    ((g == 0) ? subsystem_clock : low_speed_osc_clock),
                .rise_q (src_rise[g])
            );
        end
    endgenerate

    // timer clock gated by the peripheral enable bit, source by the speed-mode bit
    assign timer_clk_on = peren_q[`ITV_EN_BIT];                                       // R14
    assign tick  = timer_clk_on && src_rise[speed_q[`ITV_SRC_BIT]];                   // R11
    assign match = run_q && (cnt_q == cmp_q);

    // ==========================================================
    // axi write channels, address and data taken in either order
    assign s_axi_awready = !aw_full_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_full_q && !s_axi_bvalid;
    assign do_write      = aw_full_q && w_full_q && !s_axi_bvalid;
    assign wr_idx        = aw_addr_q[`ITV_ADDR_W-1:`ITV_IDX_LSB];
    assign wr_ctrl  = do_write && (wr_idx == `ITV_IDX_CTRL);
    assign wr_speed = do_write && (wr_idx == `ITV_IDX_SPEED);
    assign wr_peren = do_write && (wr_idx == `ITV_IDX_PEREN);
    assign wr_stat  = do_write && (wr_idx == `ITV_IDX_STAT);
    assign wr_mask  = do_write && (wr_idx == `ITV_IDX_MASK);
    assign wr_hit   = wr_ctrl || wr_speed || wr_peren || wr_stat || wr_mask;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_strb_q <= '0;
        end else if (ce) begin
            if (s_axi_wvalid && s_axi_wready) begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_full_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `ITV_RESP_OKAY;
        end else if (ce) begin
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `ITV_RESP_OKAY : `ITV_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // axi read channel, answer one cycle after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    assign rd_idx        = s_axi_araddr[`ITV_ADDR_W-1:`ITV_IDX_LSB];

    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        unique case (rd_idx)
            `ITV_IDX_CTRL: begin
                rd_word[`ITV_RUN_BIT]    = run_q;                                   // R5
                rd_word[`ITV_CMP_MSB:0]  = cmp_q;
            end
            `ITV_IDX_SPEED: rd_word[7:0] = speed_q;
            `ITV_IDX_PEREN: rd_word[7:0] = peren_q;
            `ITV_IDX_STAT:  rd_word[`ITV_EV_MATCH] = stat_q;
            `ITV_IDX_MASK:  rd_word[`ITV_EV_MATCH] = mask_q;
            default:        rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
            s_axi_rresp  <= `ITV_RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= rd_hit ? `ITV_RESP_OKAY : `ITV_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ==========================================================
    // configuration registers
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            peren_q <= `ITV_PEREN_RST;                                             // R15
        end else if (ce && wr_peren && w_strb_q[0]) begin
            peren_q <= w_data_q[7:0];                                              // R15
        end
    end

    // only whole-byte writes land; a missing lane leaves the register alone
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            speed_q <= `ITV_SPEED_RST;                                             // R16
        end else if (ce && wr_speed && w_strb_q[0]) begin
            speed_q <= w_data_q[7:0] & `ITV_SPEED_KEEP;                            // R16
        end
    end

    // control accepts full halfword writes only, and only with the timer clock on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_req_q <= 1'(`ITV_CTRL_RST >> `ITV_RUN_BIT);                        // R9
            cmp_q     <= `ITV_CMP_RST;                                             // R9
        end else if (ce && wr_ctrl && timer_clk_on
                     && ((w_strb_q & `ITV_STRB_HALF) == `ITV_STRB_HALF)) begin     // R10
            run_req_q <= w_data_q[`ITV_RUN_BIT];                                   // R4
            cmp_q     <= w_data_q[`ITV_CMP_MSB:0];
        end
    end

    // ==========================================================
    // run bit: start waits for a count clock edge, stop acts at once
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= 1'b0;
        end else if (ce) begin
            if (!run_req_q) begin
                run_q <= 1'b0;                                                     // R4
            end else if (tick) begin
                run_q <= 1'b1;                                                     // R5
            end
        end
    end

    // ==========================================================
    // counter: period is compare plus one count clocks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= `ITV_CNT_ZERO;
        end else if (ce) begin
            if (!run_q || !run_req_q) begin
                cnt_q <= `ITV_CNT_ZERO;                                            // R4
            end else if (tick) begin
                if (match) begin
                    cnt_q <= `ITV_CNT_ZERO;                                        // R2 R3
                end else begin
                    cnt_q <= cnt_q + `ITV_CNT_ONE;                                 // R1
                end
            end
        end
    end

    // request stays high from the match edge to the next count clock edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pulse_q <= 1'b0;
        end else if (ce && tick) begin
            irq_pulse_q <= match && run_req_q;                                     // R2 R18
        end else if (ce && !run_req_q) begin
            irq_pulse_q <= 1'b0;
        end
    end

    assign interval_irq = irq_pulse_q;                                             // R18
    // not gated by standby, so a match still wakes the chip
    assign wake_request = irq_pulse_q;                                             // R17
    assign sub_clock_peripheral_en = !(standby && cpu_on_sub_clock && speed_q[`ITV_LP_BIT]); // R13

    // ==========================================================
    // sticky status and mask; a new match beats a clearing write
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= `ITV_EV_RST;
        end else if (ce) begin
            if (tick && match && run_req_q) begin
                stat_q <= 1'b1;
            end else if (wr_stat && w_strb_q[0] && w_data_q[`ITV_EV_MATCH]) begin
                stat_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_q <= `ITV_EV_RST;
        end else if (ce && wr_mask && w_strb_q[0]) begin
            mask_q <= w_data_q[`ITV_EV_MATCH];
        end
    end

    assign irq = stat_q && mask_q;

    // ==========================================================
    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n || !ce);

    sequence s_start_write;
        wr_ctrl && timer_clk_on && (w_strb_q[1:0] == 2'h3) && w_data_q[`ITV_RUN_BIT] && !run_q && !run_req_q;
    endsequence

    // a count edge while the request stands and no new match is under way
    sequence s_irq_next_edge;
        interval_irq && tick && !match;
    endsequence

    a_count_up_step: assert property (tick && run_q && run_req_q && !match |=>   // R1
        cnt_q == $past(cnt_q) + `ITV_CNT_ONE)
        else $error("counter did not step on count edge");

    a_match_clear_irq: assert property (tick && match && run_req_q |=>           // R2
        (cnt_q == `ITV_CNT_ZERO) && interval_irq && stat_q)
        else $error("match did not clear counter and raise request");

    // run and counter follow the request one clock after it lands
    a_stop_clears_count: assert property (wr_ctrl && timer_clk_on && (w_strb_q[1:0] == 2'h3) // R4
        && !w_data_q[`ITV_RUN_BIT] |=> ##1 (!run_q && (cnt_q == `ITV_CNT_ZERO)))
        else $error("stop write did not halt and clear");

    a_run_read_delay: assert property (s_start_write |=> !run_q)                   // R5
        else $error("run bit read back before a count edge");

    a_run_rise_cause: assert property ($rose(run_q) |-> $past(tick) && $past(run_req_q)) // R5
        else $error("run bit rose without a count edge");

    a_partial_ctrl_ignored: assert property (wr_ctrl && (w_strb_q[1:0] != 2'h3) |=> // R10
        $stable(cmp_q) && $stable(run_req_q))
        else $error("partial control write landed");

    a_src_select_tick: assert property (tick |-> timer_clk_on                   // R11
        && (speed_q[`ITV_SRC_BIT] ? src_rise[1] : src_rise[0]))
        else $error("count edge from unselected source");

    a_low_power_gate: assert property (standby && cpu_on_sub_clock && speed_q[`ITV_LP_BIT] // R13
        |-> !sub_clock_peripheral_en)
        else $error("subsystem clock not stopped in low power");

    a_disabled_no_count: assert property (!timer_clk_on && run_q |=> $stable(cnt_q)) // R14
        else $error("counter moved with timer clock off");

    a_speed_byte_only: assert property (wr_speed && !w_strb_q[0] |=> $stable(speed_q)) // R16
        else $error("speed register changed without byte lane");

    a_irq_one_tick: assert property (s_irq_next_edge |=> !interval_irq)          // R18
        else $error("request wider than one count clock");

    a_wake_follows: assert property (interval_irq |-> wake_request)                // R17
        else $error("wake not raised with request");
endmodule

`default_nettype wire

//--- logic/twelve_bit_interval_timer_regs.svh
/*
 holds register indices, field positions, reset values and bus codes of the interval timer.
 assumes inclusion by bare name from the timer package and the timer module.
*/
// Behaviour
// R1: setting the run bit starts the 12-bit counter counting up each count clock.
// R2: on compare match the counter clears, keeps counting, and requests an interrupt.
// R3: period is count clock times compare plus one; compare zero is forbidden.
// R4: run bit is bit 15; writing 0 stops and clears, 1 starts.
// R5: a written run bit of 1 reads back only after one count clock.
// R6: software changes the compare field only while stopped or when flipping run.
// R7: software masks before stopping; clears pending then unmasks before restarting.
// R8: after standby exit and run write, software polls or waits one count clock.
// R9: system reset loads the control register with 0fff, stopped, maximum compare.
// R10: the control register takes only full 16-bit writes.
// R11: speed-mode bit 4 selects count clock: 0 subsystem, 1 low-speed oscillator.
// R12: software sets the source bit before use and clears it only when stopped.
// R13: low-power bit 7 stops subsystem clock to other peripherals in standby.
// R14: peripheral-enable bit 7 gates the timer clock; software sets it first.
// R15: peripheral-enable register resets to 00 and takes bit or byte writes.
// R16: speed-mode register resets to 00 and takes byte writes only.
// R17: the interval request can still wake the chip from stop and halt.
// R18: the interval request is one count clock wide per compare match.
`ifndef TWELVE_BIT_INTERVAL_TIMER_REGS_SVH
`define TWELVE_BIT_INTERVAL_TIMER_REGS_SVH

// ==========================================================
// register indices, byte address is four times the index
`define ITV_ADDR_W      22
`define ITV_IDX_LSB     2
`define ITV_IDX_SPEED   20'hf00f3
`define ITV_IDX_CTRL    20'hfff90
`define ITV_IDX_PEREN   20'hf00f0
`define ITV_IDX_STAT    20'hf00f8
`define ITV_IDX_MASK    20'hf00f9

// ==========================================================
// fields
`define ITV_RUN_BIT     15
`define ITV_CMP_MSB     11
`define ITV_SRC_BIT     4
`define ITV_LP_BIT      7
`define ITV_EN_BIT      7
`define ITV_EV_MATCH    0
`define ITV_SPEED_KEEP  8'h90

// ==========================================================
// reset values
`define ITV_CTRL_RST    16'h0fff
`define ITV_CMP_RST     12'hfff
`define ITV_SPEED_RST   8'h00
`define ITV_PEREN_RST   8'h00
`define ITV_EV_RST      1'h0
`define ITV_CNT_ZERO    12'h000
`define ITV_CNT_ONE     12'h001

// ==========================================================
// bus codes
`define ITV_RESP_OKAY   2'h0
`define ITV_RESP_SLVERR 2'h2
`define ITV_STRB_LO     4'h1
`define ITV_STRB_HALF   4'h3

`endif

//--- logic/interval_timer_pkg.sv
/*
 holds the types shared by the interval timer files.
 assumes the register header sits beside it.
*/
`include "twelve_bit_interval_timer_regs.svh"

package interval_timer_pkg;
    typedef logic [`ITV_CMP_MSB:0]   count_type;
    typedef logic [`ITV_ADDR_W-1:0]  addr_type;
    typedef logic [31:0]             word_type;
    typedef logic [3:0]              strb_type;
    typedef logic [1:0]              resp_type;
endpackage

//--- logic/pin_edge_sync.sv
/*
 holds a three-stage synchroniser for a clock pin with a rising-edge pulse.
 assumes one system clock, an asynchronous active-low reset and a clock enable.
*/
`timescale 1ns/1ps
`default_nettype none

module pin_edge_sync (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic ce,
    input  wire logic pin,
    output var  logic rise_q
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;

    // ==========================================================
    // capture chain, first stage feeds only the second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else if (ce) begin
            s1_q <= pin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // ==========================================================
    // accepted level moves only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            level_q <= 1'b0;
            rise_q  <= 1'b0;
        end else if (ce) begin
            rise_q <= (s2_q == s3_q) && s2_q && !level_q;
            if (s2_q == s3_q) begin
                level_q <= s2_q;
            end
        end
    end
endmodule

`default_nettype wire

//--- tb/tb_twelve_bit_interval_timer.sv
/*
 holds the self-checking bench of the interval timer: registers over axi4-lite, count pulses, interrupt pins.
 assumes the register header and timer package are compiled first; ce stays high throughout.
*/
`timescale 1ns/1ps
`default_nettype none
`include "twelve_bit_interval_timer_regs.svh"

module tb_twelve_bit_interval_timer;
    import interval_timer_pkg::*;
    logic      clk, rst_n, ce, subsystem_clock, low_speed_osc_clock, standby, cpu_on_sub_clock;
    logic      sub_clock_peripheral_en, interval_irq, wake_request, irq;
    addr_type  s_axi_awaddr, s_axi_araddr;
    word_type  s_axi_wdata, s_axi_rdata, d;
    strb_type  s_axi_wstrb;
    resp_type  s_axi_bresp, s_axi_rresp, r;
    logic      s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic      s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, e;
    int        errors, samples_checked, first;
    logic [7:0] lfsr_q;
    count_type cmp;

    twelve_bit_interval_timer dut_u (.clk(clk), .rst_n(rst_n), .ce(ce), .subsystem_clock(subsystem_clock),
        .low_speed_osc_clock(low_speed_osc_clock), .standby(standby), .cpu_on_sub_clock(cpu_on_sub_clock),
        .sub_clock_peripheral_en(sub_clock_peripheral_en), .interval_irq(interval_irq),
        .wake_request(wake_request), .irq(irq), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

    always #5 clk = ~clk;

    // ==========================================================
    // expectations and stimulus helpers
    function automatic logic [7:0] lfsr_step();
        lfsr_q = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        return lfsr_q;
    endfunction
    function automatic int period_exp(input count_type c);
        return int'(c) + 1;
    endfunction
    function automatic word_type speed_exp(input word_type w);
        return w & 32'h90;
    endfunction

    task automatic chk_reg(input string what, input word_type exp, input word_type seen);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic chk_pin(input string what, input logic exp, input logic seen);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %b seen %b", what, exp, seen);
        end
    endtask

    // ==========================================================
    // bus master: handshakes are sampled on the rising edge, and signals move by nba right after it
    task automatic wr(input logic [19:0] idx, input word_type v, input strb_type s);
        bit ad, wd, gb;
        ad = 0; wd = 0; gb = 0;
        @(posedge clk);
        s_axi_awaddr <= {idx, 2'h0}; s_axi_awvalid <= 1; s_axi_wdata <= v; s_axi_wstrb <= s;
        s_axi_wvalid <= 1; s_axi_bready <= 1;
        while (!gb) begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) ad = 1;
            if (s_axi_wvalid && s_axi_wready) wd = 1;
            if (s_axi_bvalid) gb = 1;
            if (ad) s_axi_awvalid <= 0;
            if (wd) s_axi_wvalid <= 0;
            if (gb) s_axi_bready <= 0;
        end
    endtask
    task automatic axi_read(input logic [19:0] idx, output word_type v, output resp_type rs);
        bit ad, gr;
        ad = 0; gr = 0;
        @(posedge clk);
        s_axi_araddr <= {idx, 2'h0}; s_axi_arvalid <= 1; s_axi_rready <= 1;
        while (!gr) begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) ad = 1;
            if (s_axi_rvalid) begin
                gr = 1; v = s_axi_rdata; rs = s_axi_rresp;
            end
            if (ad) s_axi_arvalid <= 0;
            if (gr) s_axi_rready <= 0;
        end
    endtask
    task automatic rd_chk(input string what, input logic [19:0] idx, input word_type exp);
        axi_read(idx, d, r);
        chk_reg(what, exp, d);
    endtask
    // count pulses are slow against clk so the three-flop sampler always sees them
    task automatic pulse(input bit osc);
        @(posedge clk);
        if (osc) low_speed_osc_clock <= 1; else subsystem_clock <= 1;
        repeat (8) @(posedge clk);
        low_speed_osc_clock <= 0; subsystem_clock <= 0;
        repeat (8) @(posedge clk);
        @(negedge clk);
    endtask

    task automatic report_and_stop();
        $display("checked %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        $display("MISMATCH watchdog expected finish seen hang");
        report_and_stop();
    end

    // ==========================================================
    // main sequence
    initial begin
        clk = 0; rst_n = 0; ce = 1; subsystem_clock = 0; low_speed_osc_clock = 0; standby = 0;
        cpu_on_sub_clock = 0; s_axi_awaddr = '0; s_axi_awvalid = 0; s_axi_wdata = '0; s_axi_wstrb = '0;
        s_axi_wvalid = 0; s_axi_bready = 0; s_axi_araddr = '0; s_axi_arvalid = 0; s_axi_rready = 0;
        errors = 0; samples_checked = 0; lfsr_q = 8'h18;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        rd_chk("ctrl_reset", `ITV_IDX_CTRL, 32'h0fff);
        rd_chk("speed_reset", `ITV_IDX_SPEED, 32'h0);
        rd_chk("peren_reset", `ITV_IDX_PEREN, 32'h0);
        rd_chk("status_reset", `ITV_IDX_STAT, 32'h0);
        rd_chk("mask_reset", `ITV_IDX_MASK, 32'h0);
        axi_read(20'h00001, d, r);
        chk_reg("unmapped_resp", {30'h0, `ITV_RESP_SLVERR}, {30'h0, r});
        $display("test reset_values done");
        wr(`ITV_IDX_CTRL, 32'h8005, `ITV_STRB_HALF);
        rd_chk("ctrl_gated", `ITV_IDX_CTRL, 32'h0fff);
        wr(`ITV_IDX_PEREN, 32'h80, `ITV_STRB_LO);
        rd_chk("peren_set", `ITV_IDX_PEREN, 32'h80);
        wr(`ITV_IDX_CTRL, 32'h8005, `ITV_STRB_LO);
        rd_chk("ctrl_byte_write", `ITV_IDX_CTRL, 32'h0fff);
        wr(`ITV_IDX_SPEED, 32'hff, `ITV_STRB_LO);
        rd_chk("speed_bits", `ITV_IDX_SPEED, speed_exp(32'hff));
        wr(`ITV_IDX_SPEED, 32'h0, 4'h2);
        rd_chk("speed_lane", `ITV_IDX_SPEED, speed_exp(32'hff));
        standby <= 1; cpu_on_sub_clock <= 1;
        @(negedge clk);
        chk_pin("sub_gate_low", 0, sub_clock_peripheral_en);
        wr(`ITV_IDX_SPEED, 32'h10, `ITV_STRB_LO);
        @(negedge clk);
        chk_pin("sub_gate_high", 1, sub_clock_peripheral_en);
        @(posedge clk);
        standby <= 0; cpu_on_sub_clock <= 0;
        $display("test config_regs done");
        for (int k = 0; k < 3; k++) begin
            cmp = (k == 0) ? 12'h001 : 12'(2 + lfsr_step() % 6);
            wr(`ITV_IDX_MASK, 32'h1, `ITV_STRB_LO);
            wr(`ITV_IDX_CTRL, {16'h0, 1'b1, 3'h0, cmp}, `ITV_STRB_HALF);
            rd_chk("run_before_edge", `ITV_IDX_CTRL, {20'h0, cmp});
            repeat (3) pulse(0);
            rd_chk("run_wrong_source", `ITV_IDX_CTRL, {20'h0, cmp});
            chk_pin("idle_wrong_source", 0, interval_irq);
            pulse(1);
            rd_chk("run_after_edge", `ITV_IDX_CTRL, {16'h0, 1'b1, 3'h0, cmp});
            first = -1;
            for (int i = 0; i < 3 * period_exp(cmp); i++) begin
                pulse(1);
                if (first < 0) begin
                    if (interval_irq === 1'b1) first = i;
                end else begin
                    e = ((i - first) % period_exp(cmp)) == 0;
                    chk_pin("irq_pulse", e, interval_irq);
                    chk_pin("wake_pulse", e, wake_request);
                end
            end
            chk_reg("irq_seen", 32'h1, {31'h0, first >= 0});
            chk_pin("irq_unmasked", 1, irq);
            rd_chk("status_set", `ITV_IDX_STAT, 32'h1);
            wr(`ITV_IDX_MASK, 32'h0, `ITV_STRB_LO);
            @(negedge clk);
            chk_pin("irq_masked", 0, irq);
            wr(`ITV_IDX_CTRL, {20'h0, cmp}, `ITV_STRB_HALF);
            @(negedge clk);
            chk_pin("irq_on_stop", 0, interval_irq);
            rd_chk("run_cleared", `ITV_IDX_CTRL, {20'h0, cmp});
            wr(`ITV_IDX_STAT, 32'h1, `ITV_STRB_LO);
            rd_chk("status_clear", `ITV_IDX_STAT, 32'h0);
            $display("test interval cmp %h done", cmp);
        end
        // timer clock switched off while running: count and request must freeze
        wr(`ITV_IDX_CTRL, 32'h8001, `ITV_STRB_HALF);
        pulse(1);
        wr(`ITV_IDX_PEREN, 32'h0, `ITV_STRB_LO);
        repeat (4) pulse(1);
        chk_pin("irq_clock_off", 0, interval_irq);
        rd_chk("run_clock_off", `ITV_IDX_CTRL, 32'h8001);
        $display("test clock_off done");
        report_and_stop();
    end
endmodule

`default_nettype wire
